// *** reg_file_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module reg_file_model (
    // selection
    input wire logic [3:0] regSel,
    // contents
    output logic [15:0] regWord,
    output logic [15:0] regPairHigh,
    output logic [15:0] regPairLow
);
    logic [15:0] regs [16];
    assign regWord = regs[regSel];
    assign regPairHigh = regs[{regSel[3:1], 1'b0}];
    assign regPairLow = regs[{regSel[3:1], 1'b1}];
endmodule : reg_file_model

`default_nettype wire

// *** seg_addr_chk.sv ***
`timescale 1ns/100ps
`default_nettype none

module seg_addr_chk #(
    parameter int SEG_W = 7,
    parameter int OFS_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // request
    input wire logic reqValid,
    input wire seg_addr_pkg::mode_type mode,
    input wire seg_addr_pkg::class_type instrClass,
    input wire logic longFormat,
    input wire logic [3:0] regSel,
    input wire logic [SEG_W-1:0] instrSeg,
    input wire logic [OFS_W-1:0] instrWord1,
    input wire logic [OFS_W-1:0] instrWord2,
    input wire logic [OFS_W-1:0] regWord,
    input wire logic [OFS_W-1:0] regPairHigh,
    input wire logic [OFS_W-1:0] regPairLow,
    input wire logic [SEG_W-1:0] pcSeg,
    input wire logic [OFS_W-1:0] pcNextOfs,
    // answer
    input wire logic addrValid,
    input wire logic [SEG_W-1:0] addrSeg,
    input wire logic [OFS_W-1:0] addrOfs,
    input wire seg_addr_pkg::space_type addrSpace,
    input wire logic [1:0] addrWords,
    input wire logic pcLoad,
    input wire logic addrError,
    input wire logic [1:0] errorCode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [OFS_W-1:0] idxSum;
    always_ff @(posedge ref_clk) begin
        idxSum <= regWord + (longFormat ? instrWord2 : OFS_W'(instrWord1[7:0]));
    end
    sequence rel_req;
        reqValid && mode == seg_addr_pkg::MODE_RELATIVE;
    endsequence
    sequence idx_req;
        reqValid && mode == seg_addr_pkg::MODE_INDEXED && regSel != 4'h0;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    answer_once_a: assert property (
        reqValid |=> addrValid != addrError) else $error("request without single answer");
    idle_quiet_a: assert property (
        !reqValid |=> !addrValid && !addrError && !pcLoad) else $error("answer without request");
    held_result_a: assert property (
        !reqValid |=> $stable(addrOfs) && $stable(addrSeg) && $stable(addrSpace))
        else $error("result not held");
    zero_pointer_a: assert property (
        reqValid && regSel == 4'h0 && mode inside {seg_addr_pkg::MODE_INDIRECT,
        seg_addr_pkg::MODE_INDEXED} |=> addrError && errorCode == seg_addr_pkg::ERR_REG_ZERO)
        else $error("zero pointer not flagged");
    based_load_a: assert property (
        reqValid && mode == seg_addr_pkg::MODE_BASED && instrClass != seg_addr_pkg::CLS_LOAD
        && regSel != 4'h0 |=> addrError && errorCode == seg_addr_pkg::ERR_MODE_CLASS)
        else $error("based mode outside load family");
    rel_segment_a: assert property (
        rel_req |=> addrSeg == $past(pcSeg) && addrSpace == seg_addr_pkg::SPACE_PROGRAM)
        else $error("relative segment or space wrong");
    idx_offset_a: assert property (
        idx_req |=> addrOfs == idxSum && addrSeg == $past(instrSeg)
        && addrSpace == seg_addr_pkg::SPACE_DATA) else $error("indexed address wrong");
    stack_pair_a: assert property (
        reqValid && regSel == seg_addr_pkg::STACK_PAIR && instrClass == seg_addr_pkg::CLS_LOAD
        && mode inside {seg_addr_pkg::MODE_BASED, seg_addr_pkg::MODE_INDIRECT}
        |=> addrSpace == seg_addr_pkg::SPACE_STACK) else $error("stack pair not stack space");
    direct_jump_a: assert property (
        reqValid && mode == seg_addr_pkg::MODE_DIRECT && instrClass == seg_addr_pkg::CLS_JUMP_CALL
        |=> pcLoad && addrSpace == seg_addr_pkg::SPACE_PROGRAM) else $error("direct jump no load");
endmodule : seg_addr_chk

bind segmented_operand_address_gen seg_addr_chk #(.SEG_W(SEG_W), .OFS_W(OFS_W)) chk (.*);

`default_nettype wire

// *** seg_addr_pkg.sv ***
package seg_addr_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SEG_W = 7;
    localparam int OFS_W = 16;
    localparam int REG_W = 4;
    localparam int SHORT_OFS_W = 8;

    // ------------------------------------------------------------
    // register numbers
    // ------------------------------------------------------------
    localparam logic [3:0] REG_ZERO = 4'h0;
    localparam logic [3:0] STACK_PAIR = 4'he;

    // ------------------------------------------------------------
    // addressing modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_INDIRECT,
        MODE_DIRECT,
        MODE_INDEXED,
        MODE_RELATIVE,
        MODE_BASED
    } mode_type;

    // ------------------------------------------------------------
    // instruction classes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CLS_MEMORY,
        CLS_IO,
        CLS_SPECIAL_IO,
        CLS_LOAD,
        CLS_JUMP_CALL,
        CLS_DEC_JUMP_NZ,
        CLS_REL_CALL
    } class_type;

    // ------------------------------------------------------------
    // address spaces
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SPACE_NONE,
        SPACE_IO,
        SPACE_SPECIAL_IO,
        SPACE_DATA,
        SPACE_STACK,
        SPACE_PROGRAM
    } space_type;

    // ------------------------------------------------------------
    // error codes
    // ------------------------------------------------------------
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_REG_ZERO = 2'h1;
    localparam logic [1:0] ERR_MODE_CLASS = 2'h2;

endpackage : seg_addr_pkg

// *** seg_offset_adder.sv ***
`timescale 1ns/100ps
`default_nettype none

module seg_offset_adder #(
    parameter int OFS_W = 16
) (
    // operands
    input wire logic [OFS_W-1:0] base,
    input wire logic [OFS_W-1:0] operand,
    input wire logic subtract,
    // result
    output logic [OFS_W-1:0] result
);

    // carry dropped: segment never bumps
    always_comb begin
        if (subtract) begin
            result = base - operand;
        end else begin
            result = base + operand;
        end
    end

endmodule : seg_offset_adder

`default_nettype wire

// *** segmented_operand_address_gen.sv ***
// Contract
// - indirect mode: I/O class to I/O, special I/O to special, else memory.
// - indirect memory reference in stack space for stack pair, else data space.
// - indirect I/O address from one word register, memory from a pair.
// - indirect pointer may be any register or pair except zero.
// - direct mode: standard I/O to I/O space, special I/O to special, jump/call to program, else data space.
// - direct I/O address one word; memory one word short, two long.
// - direct jump or call loads the carried address into program counter.
// - indexed offset is index register plus 8- or 16-bit instruction offset.
// - indexed segment comes unchanged from the instruction address.
// - indexed carry discarded; no overflow flag, no segment increment.
// - any index register except zero; one- or two-word instruction address.
// - indexed operands always in data space.
// - relative adds signed displacement to next-instruction counter offset.
// - relative operands in program space; one-word format only, longFormat ignored.
// - relative transfers load the sum; decrement-jump and relative call subtract.
// - relative target keeps the program counter segment.
// - based adds 16-bit displacement to pair base offset, segment unchanged.
// - based mode allowed only for the load family.
// - based base may be any pair; only regSel zero is rejected, so regSel 1 still reaches pair zero.
// - based operands in stack space for stack pair, else data space.
`timescale 1ns/100ps
`default_nettype none

module segmented_operand_address_gen #(
    parameter int SEG_W = seg_addr_pkg::SEG_W,
    parameter int OFS_W = seg_addr_pkg::OFS_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // request from decoder
    input wire logic reqValid,
    input wire seg_addr_pkg::mode_type mode,
    input wire seg_addr_pkg::class_type instrClass,
    input wire logic longFormat,
    input wire logic [3:0] regSel,
    input wire logic [SEG_W-1:0] instrSeg,
    input wire logic [OFS_W-1:0] instrWord1,
    input wire logic [OFS_W-1:0] instrWord2,
    // register file and program counter
    input wire logic [OFS_W-1:0] regWord,
    input wire logic [OFS_W-1:0] regPairHigh,
    input wire logic [OFS_W-1:0] regPairLow,
    input wire logic [SEG_W-1:0] pcSeg,
    input wire logic [OFS_W-1:0] pcNextOfs,
    // answer to bus interface
    output logic addrValid,
    output logic [SEG_W-1:0] addrSeg,
    output logic [OFS_W-1:0] addrOfs,
    output seg_addr_pkg::space_type addrSpace,
    output logic [1:0] addrWords,
    output logic pcLoad,
    output logic addrError,
    output logic [1:0] errorCode
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic isZeroReg(input logic [3:0] r);
        return r == seg_addr_pkg::REG_ZERO;
    endfunction : isZeroReg

    function automatic seg_addr_pkg::space_type memSpace(input logic [3:0] r);
        return (r == seg_addr_pkg::STACK_PAIR) ? seg_addr_pkg::SPACE_STACK
                                               : seg_addr_pkg::SPACE_DATA;
    endfunction : memSpace

    // pair holds segment in high word bits 14:8
    function automatic logic [SEG_W-1:0] pairSeg(input logic [OFS_W-1:0] hi);
        return hi[SEG_W+7:8];
    endfunction : pairSeg

    // ------------------------------------------------------------
    // combinational address forming
    // ------------------------------------------------------------
    logic [OFS_W-1:0] addBase;
    logic [OFS_W-1:0] addOperand;
    logic addSubtract;
    logic [OFS_W-1:0] sum;
    logic [SEG_W-1:0] next_seg;
    logic [OFS_W-1:0] next_ofs;
    seg_addr_pkg::space_type next_space;
    logic [1:0] next_words;
    logic next_pcLoad;
    logic [1:0] next_err;
    logic [OFS_W-1:0] instrOfs;
    logic isIo;

    // short form keeps 8-bit offset in low byte
    always_comb begin
        if (longFormat) begin
            instrOfs = instrWord2;
        end else begin
            instrOfs = {{(OFS_W-seg_addr_pkg::SHORT_OFS_W){1'b0}},
                        instrWord1[seg_addr_pkg::SHORT_OFS_W-1:0]};
        end
    end

    assign isIo = (instrClass == seg_addr_pkg::CLS_IO)
               || (instrClass == seg_addr_pkg::CLS_SPECIAL_IO);

    seg_offset_adder #(
        .OFS_W(OFS_W)
    ) offsetAdder (
        .base(addBase),
        .operand(addOperand),
        .subtract(addSubtract),
        .result(sum)
    );

    always_comb begin
        addBase = '0;
        addOperand = '0;
        addSubtract = 1'b0;
        next_seg = '0;
        next_ofs = '0;
        next_space = seg_addr_pkg::SPACE_NONE;
        next_words = 2'h0;
        next_pcLoad = 1'b0;
        next_err = seg_addr_pkg::ERR_NONE;
        unique case (mode)
            seg_addr_pkg::MODE_INDIRECT: begin
                if (isZeroReg(regSel)) begin
                    next_err = seg_addr_pkg::ERR_REG_ZERO;
                end else if (isIo) begin
                    next_ofs = regWord;
                    next_space = (instrClass == seg_addr_pkg::CLS_IO)
                        ? seg_addr_pkg::SPACE_IO
                        : seg_addr_pkg::SPACE_SPECIAL_IO;
                end else begin
                    next_seg = pairSeg(regPairHigh);
                    next_ofs = regPairLow;
                    next_space = memSpace(regSel);
                end
            end
            seg_addr_pkg::MODE_DIRECT: begin
                if (isIo) begin
                    next_ofs = instrWord1;
                    next_words = 2'h1;
                    next_space = (instrClass == seg_addr_pkg::CLS_IO)
                        ? seg_addr_pkg::SPACE_IO
                        : seg_addr_pkg::SPACE_SPECIAL_IO;
                end else begin
                    next_seg = instrSeg;
                    next_ofs = instrOfs;
                    next_words = longFormat ? 2'h2 : 2'h1;
                    if (instrClass == seg_addr_pkg::CLS_JUMP_CALL) begin
                        next_space = seg_addr_pkg::SPACE_PROGRAM;
                        next_pcLoad = 1'b1;
                    end else begin
                        next_space = seg_addr_pkg::SPACE_DATA;
                    end
                end
            end
            seg_addr_pkg::MODE_INDEXED: begin
                next_words = longFormat ? 2'h2 : 2'h1;
                if (isZeroReg(regSel)) begin
                    next_err = seg_addr_pkg::ERR_REG_ZERO;
                end else begin
                    addBase = instrOfs;
                    addOperand = regWord;
                    next_seg = instrSeg;
                    next_ofs = sum;
                    next_space = seg_addr_pkg::SPACE_DATA;
                end
            end
            seg_addr_pkg::MODE_RELATIVE: begin
                addBase = pcNextOfs;
                addOperand = instrWord1;
                next_seg = pcSeg;
                next_space = seg_addr_pkg::SPACE_PROGRAM;
                next_words = 2'h1;
                unique case (instrClass)
                    seg_addr_pkg::CLS_DEC_JUMP_NZ,
                    seg_addr_pkg::CLS_REL_CALL: begin
                        addSubtract = 1'b1;
                        next_pcLoad = 1'b1;
                    end
                    seg_addr_pkg::CLS_JUMP_CALL: begin
                        next_pcLoad = 1'b1;
                    end
                    default: begin
                        next_pcLoad = 1'b0;
                    end
                endcase
                next_ofs = sum;
            end
            seg_addr_pkg::MODE_BASED: begin
                next_words = 2'h1;
                if (instrClass != seg_addr_pkg::CLS_LOAD) begin
                    next_err = seg_addr_pkg::ERR_MODE_CLASS;
                end else if (isZeroReg(regSel)) begin
                    next_err = seg_addr_pkg::ERR_REG_ZERO;
                end else begin
                    addBase = regPairLow;
                    addOperand = instrWord1;
                    next_seg = pairSeg(regPairHigh);
                    next_ofs = sum;
                    next_space = memSpace(regSel);
                end
            end
            default: begin
                next_err = seg_addr_pkg::ERR_MODE_CLASS;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registered answer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addrValid <= 1'b0;
            addrError <= 1'b0;
        end else begin
            addrValid <= reqValid && (next_err == seg_addr_pkg::ERR_NONE);
            addrError <= reqValid && (next_err != seg_addr_pkg::ERR_NONE);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addrSeg <= '0;
            addrOfs <= '0;
            addrSpace <= seg_addr_pkg::SPACE_NONE;
            addrWords <= 2'h0;
            pcLoad <= 1'b0;
            errorCode <= seg_addr_pkg::ERR_NONE;
        end else if (reqValid) begin
            addrSeg <= next_seg;
            addrOfs <= next_ofs;
            addrSpace <= next_space;
            addrWords <= next_words;
            pcLoad <= next_pcLoad && (next_err == seg_addr_pkg::ERR_NONE);
            errorCode <= next_err;
        end else begin
            pcLoad <= 1'b0;
        end
    end

endmodule : segmented_operand_address_gen

`default_nettype wire

// *** tb_segmented_operand_address_gen.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_segmented_operand_address_gen;
    logic ref_clk = 0, srst = 1, reqValid = 0, longFormat = 0;
    seg_addr_pkg::mode_type mode = seg_addr_pkg::MODE_INDIRECT;
    seg_addr_pkg::class_type instrClass = seg_addr_pkg::CLS_MEMORY;
    seg_addr_pkg::space_type addrSpace;
    logic [3:0] regSel = 4'h1;
    logic [6:0] instrSeg = 7'h00, pcSeg = 7'h00, addrSeg;
    logic [15:0] instrWord1 = 16'h0000, instrWord2 = 16'h0000, pcNextOfs = 16'h0000, addrOfs;
    logic [15:0] regWord, regPairHigh, regPairLow;
    logic addrValid, pcLoad, addrError;
    logic [1:0] addrWords, errorCode;
    int n_fail = 0, samples_checked = 0, pend = 0;
    int eErr, eSeg, eOfs, eSp, eWds, ePc;

    segmented_operand_address_gen DUT (.*);
    reg_file_model RF (.*);

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // spaces: 1 io, 2 special io, 3 data, 4 stack, 5 program
    task automatic predict;
        int c, r, ofs, io, regWord, regPairHigh, regPairLow;
        c = instrClass;
        r = regSel;
        // read the model's array directly: its continuous outputs lag regSel here
        regWord = RF.regs[regSel];
        regPairHigh = RF.regs[{regSel[3:1], 1'b0}];
        regPairLow = RF.regs[{regSel[3:1], 1'b1}];
        io = c inside {1, 2};
        ofs = longFormat ? instrWord2 : instrWord1[7:0];
        eErr = r == 0 ? 1 : 0;
        eSeg = -1;
        eWds = -1;
        ePc = 0;
        case (int'(mode))
            0: begin
                eSp = io ? c : r == 14 ? 4 : 3;
                eSeg = io ? 0 : (regPairHigh >> 8) & 'h7f;
                eOfs = io ? regWord : regPairLow;
            end
            1: begin
                eErr = 0;
                eSp = io ? c : c == 4 ? 5 : 3;
                eWds = io ? 1 : 1 + longFormat;
                eOfs = io ? instrWord1 : ofs;
                eSeg = io ? -1 : instrSeg;
                ePc = c == 4;
            end
            2: begin
                eSp = 3;
                eSeg = instrSeg;
                eWds = 1 + longFormat;
                eOfs = (regWord + ofs) & 'hffff;
            end
            3: begin
                eErr = 0;
                eSp = 5;
                eSeg = pcSeg;
                eWds = 1;
                ePc = c > 3;
                eOfs = (c > 4 ? pcNextOfs - instrWord1 : pcNextOfs + instrWord1) & 'hffff;
            end
            default: begin
                eErr = c != 3 ? 2 : r == 0 ? 1 : 0;
                eSp = r == 14 ? 4 : 3;
                eSeg = (regPairHigh >> 8) & 'h7f;
                eWds = 1;
                eOfs = (regPairLow + instrWord1) & 'hffff;
            end
        endcase
    endtask : predict

    task automatic check;
        cmp(addrError, eErr != 0);
        cmp(addrValid, eErr == 0);
        cmp(errorCode, eErr);
        cmp(pcLoad, eErr == 0 && ePc);
        if (eErr == 0) begin
            cmp(addrSpace, eSp);
            cmp(addrOfs, eOfs);
            if (eSeg >= 0) cmp(addrSeg, eSeg);
            if (eWds >= 0) cmp(addrWords, eWds);
        end
    endtask : check

    task automatic run(input int n);
        int m, c;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            if (pend) check;
            else cmp(addrValid, 0);
            RF.regs[$urandom % 16] = $urandom;
            m = $urandom % 5;
            c = $urandom % 7;
            regSel = $urandom;
            case (m)
                0: c = c % 4;
                1: c = c > 4 ? 4 : c;
                2: c = c % 2 ? 3 : 0;
                3: c = c inside {1, 2} ? 3 : c;
                default: c = regSel == 0 ? 3 : c;
            endcase
            mode = seg_addr_pkg::mode_type'(m);
            instrClass = seg_addr_pkg::class_type'(c);
            {longFormat, instrSeg, pcSeg} = $urandom;
            {instrWord1, instrWord2} = $urandom;
            pcNextOfs = $urandom;
            reqValid = $urandom % 4 != 0;
            pend = reqValid;
            if (reqValid) predict;
        end
    endtask : run

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    initial begin
        for (int i = 0; i < 16; i++) RF.regs[i] = 16'h0000;
        void'($urandom(48));
        repeat (16) @(posedge ref_clk);
        #1;
        srst = 0;
        cmp(addrSpace, seg_addr_pkg::SPACE_NONE);
        // worked indexed example, long offset
        RF.regs[3] = 16'h01fe;
        regSel = 4'h3;
        mode = seg_addr_pkg::MODE_INDEXED;
        instrSeg = 7'h05;
        longFormat = 1;
        instrWord2 = 16'h231a;
        reqValid = 1;
        predict;
        @(posedge ref_clk);
        #1;
        check;
        cmp(addrOfs, 32'h2518);
        reqValid = 0;
        $display("test walk done");
        run(1500);
        srst = 1;
        reqValid = 0;
        @(posedge ref_clk);
        #1;
        srst = 0;
        pend = 0;
        cmp(addrSpace, seg_addr_pkg::SPACE_NONE);
        cmp(addrValid, 0);
        $display("test reset done");
        run(1500);
        $display("test random done");
        conclude;
    end
endmodule : tb_segmented_operand_address_gen

`default_nettype wire
